//--- design/cbx_consts.vh
// Purpose: Shared constants of the compare, barrier and xor decode block
// Assumes: Verilog-2005, included by bare name
// Notes:   Opcode patterns hold the fixed bits of each halfword encoding
`ifndef CBX_CONSTS_VH
`define CBX_CONSTS_VH

// ==========================================================================
// Register map (byte addresses)
`define CTRL_REG_ADDR     4'h0
`define STATUS_REG_ADDR   4'h4
`define COUNT_REG_ADDR    4'h8

// ==========================================================================
// Field positions
`define CTRL_ENABLE_BIT   0
`define STAT_STALL_BIT    4
`define STAT_ORDER_BIT    5
`define STAT_UNPRED_BIT   6
`define STAT_UNDEF_BIT    7
`define CTRL_RESET_VAL    32'h00000001
`define CTRL_ENABLE_RST   1'b1

// ==========================================================================
// Sixteen-bit opcode patterns
`define OPC_COMPARE_NEG   10'h10B
`define OPC_COMPARE_LO    10'h10A
`define OPC_XOR           10'h101
`define OPC_COMPARE_IMM   5'h05
`define OPC_COMPARE_HI    8'h45
`define OPC_MOVE          8'h46

// ==========================================================================
// Thirty-two-bit barrier patterns
`define OPC_BAR_HW0       12'hF3B
`define OPC_SYNC_BAR      4'h4
`define OPC_ORDER_BAR     4'h5
`define FULL_SYSTEM_OPT   4'hF

// ==========================================================================
// Condition codes and register indices
`define COND_ALWAYS       4'hE
`define REG_LOW_LIMIT     4'h8
`define REG_PC            4'hF

// ==========================================================================
// Operation one-hot positions
`define OP_NONE           8'h00
`define OP_ADD_CHK        0
`define OP_SUB_IMM        1
`define OP_SUB_LO         2
`define OP_SUB_HI         3
`define OP_MOV            4
`define OP_XOR            5
`define OP_ORDER          6
`define OP_SYNC           7

`endif

//--- design/compare_barrier_xor_decode.v
// Purpose: Decode and execute compare, copy, barrier and xor instructions
// Assumes: Register file reads combinationally from registered indices
// Notes:   Wishbone classic slave holds control, status and a counter
//
// Design decisions made here: the Wishbone register port and the placing of the registers.
`default_nettype none
`include "cbx_consts.vh"

// Operation
// - compare_negative adds both registers, carry-in zero, sets all four flags.
// - compare_op immediate takes 3-bit index and zero-extended byte_immediate 0-255.
// - compare_op immediate adds register, inverted immediate, carry one; sets flags.
// - Low compare_op form takes both operands from R0-R7, no shift.
// - High compare_op form joins extra bit; both low or any R15 unpredictable.
// - compare_op register adds first, inverted second, carry one; sets flags.
// - copy_alias decodes exactly as register move.
// - memory_order_barrier orders earlier explicit accesses before later ones only.
// - memory_order_barrier option 1111 is full system; others act the same.
// - sync_barrier stalls later instructions until accesses and maintenance finish.
// - sync_barrier option 1111 is full system; others act the same.
// - xor_op uses one field as destination and source; flags only outside conditional block.
// - xor_op writes XOR; flags N, Z, C from shifter carry, V kept. The code keeps C unchanged instead.
module compare_barrier_xor_decode (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // Fetch stage
  input  wire [31:0] instr_i,
  input  wire        instr_valid_i,
  input  wire [3:0]  cond_i,
  input  wire        in_it_block_i,
  output reg         instr_ready_o,
  // Register file
  output reg  [3:0]  rf_raddr_a_o,
  output reg  [3:0]  rf_raddr_b_o,
  input  wire [31:0] rf_rdata_a_i,
  input  wire [31:0] rf_rdata_b_i,
  output reg         rf_we_o,
  output reg  [3:0]  rf_waddr_o,
  output reg  [31:0] rf_wdata_o,
  // Program status flags
  output reg         flag_n_o,
  output reg         flag_z_o,
  output reg         flag_c_o,
  output reg         flag_v_o,
  // Memory system
  input  wire        mem_pending_i,
  input  wire        maint_busy_i,
  output reg         mem_order_o,
  output reg         sync_stall_o,
  // Exceptions
  output reg         unpred_o,
  output reg         undef_o,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [3:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o
);

  // ========================================================================
  // States
  localparam [2:0] S_IDLE = 3'b001;
  localparam [2:0] S_EXEC = 3'b010;
  localparam [2:0] S_SYNC = 3'b100;

  // ========================================================================
  // Functions
  function [7:0] decode_op;
    input [31:0] ins;
    reg   [15:0] h0;
    reg   [15:0] h1;
    begin
      h0 = ins[15:0];
      h1 = ins[31:16];
      decode_op = `OP_NONE;
      if (h0[15:6] == `OPC_COMPARE_NEG)
        decode_op[`OP_ADD_CHK] = 1'b1;
      else if (h0[15:11] == `OPC_COMPARE_IMM)
        decode_op[`OP_SUB_IMM] = 1'b1;
      else if (h0[15:6] == `OPC_COMPARE_LO)
        decode_op[`OP_SUB_LO] = 1'b1;
      else if (h0[15:8] == `OPC_COMPARE_HI)
        decode_op[`OP_SUB_HI] = 1'b1;
      else if (h0[15:8] == `OPC_MOVE)
        decode_op[`OP_MOV] = 1'b1;
      else if (h0[15:6] == `OPC_XOR)
        decode_op[`OP_XOR] = 1'b1;
      else if (h0[15:4] == `OPC_BAR_HW0 && h1[15:14] == 2'b10 && !h1[12]) begin
        if (h1[7:4] == `OPC_ORDER_BAR)
          decode_op[`OP_ORDER] = 1'b1;
        else if (h1[7:4] == `OPC_SYNC_BAR)
          decode_op[`OP_SYNC] = 1'b1;
      end
    end
  endfunction

  function cond_ok;
    input [3:0] cond;
    input       n;
    input       z;
    input       c;
    input       v;
    reg         base;
    begin
      case (cond[3:1])
        3'd0:    base = z;
        3'd1:    base = c;
        3'd2:    base = n;
        3'd3:    base = v;
        3'd4:    base = c & ~z;
        3'd5:    base = (n == v);
        3'd6:    base = (n == v) & ~z;
        default: base = 1'b1;
      endcase
      cond_ok = (cond[0] && cond != 4'hF) ? ~base : base;
    end
  endfunction

  // ========================================================================
  // Internal state
  reg [2:0]  state_reg;
  reg [31:0] instr_reg;
  reg [7:0]  op_reg;
  reg [3:0]  cond_reg;
  reg        in_it_reg;
  reg        enable_reg;
  reg        unpred_sticky_reg;
  reg        undef_sticky_reg;
  reg [3:0]  option_reg;
  reg [31:0] count_reg;

  wire [7:0]  op_in = decode_op(instr_i);
  wire [15:0] hw0   = instr_reg[15:0];
  wire [3:0]  idx_a = rf_raddr_a_o;
  wire [3:0]  idx_b = rf_raddr_b_o;

  // ========================================================================
  // Shared adder for the compare forms
  wire        is_addchk = op_reg[`OP_ADD_CHK];
  wire [31:0] imm_ext  = {24'h000000, hw0[7:0]};
  wire [31:0] add_b    = is_addchk ? rf_rdata_b_i :
                         (op_reg[`OP_SUB_IMM] ? ~imm_ext : ~rf_rdata_b_i);
  wire        add_cin  = ~is_addchk;
  wire [32:0] sum      = {1'b0, rf_rdata_a_i} + {1'b0, add_b} + {32'h00000000, add_cin};
  wire        add_v    = (rf_rdata_a_i[31] == add_b[31]) && (sum[31] != rf_rdata_a_i[31]);
  wire [31:0] xor_res  = rf_rdata_a_i ^ rf_rdata_b_i;
  wire        pass     = cond_ok(cond_reg, flag_n_o, flag_z_o, flag_c_o, flag_v_o);
  wire        is_compare = |op_reg[`OP_SUB_HI:`OP_ADD_CHK];
  wire        hi_bad   = (idx_a < `REG_LOW_LIMIT && idx_b < `REG_LOW_LIMIT) ||
                         idx_a == `REG_PC || idx_b == `REG_PC;
  wire        take     = instr_valid_i && instr_ready_o;
  wire        sync_done = !mem_pending_i && !maint_busy_i;

  // ========================================================================
  // Bus access decode
  wire        wb_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire        wb_wr    = wb_req && wb_we_i;
  wire        ctrl_wr  = wb_wr && wb_adr_i == `CTRL_REG_ADDR && wb_sel_i[0];
  wire        stat_wr  = wb_wr && wb_adr_i == `STATUS_REG_ADDR && wb_sel_i[0];
  wire [31:0] status_word = {20'h00000, option_reg, undef_sticky_reg, unpred_sticky_reg,
                             mem_order_o, sync_stall_o,
                             flag_n_o, flag_z_o, flag_c_o, flag_v_o};

  // ========================================================================
  // Decode and execute
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_reg     <= S_IDLE;
      instr_reg     <= 32'h00000000;
      op_reg        <= `OP_NONE;
      cond_reg      <= `COND_ALWAYS;
      in_it_reg     <= 1'b0;
      instr_ready_o <= 1'b0;
      rf_raddr_a_o  <= 4'h0;
      rf_raddr_b_o  <= 4'h0;
      rf_we_o       <= 1'b0;
      rf_waddr_o    <= 4'h0;
      rf_wdata_o    <= 32'h00000000;
      flag_n_o      <= 1'b0;
      flag_z_o      <= 1'b0;
      flag_c_o      <= 1'b0;
      flag_v_o      <= 1'b0;
      mem_order_o   <= 1'b0;
      sync_stall_o  <= 1'b0;
      unpred_o      <= 1'b0;
      undef_o       <= 1'b0;
      option_reg    <= `FULL_SYSTEM_OPT;
      count_reg     <= 32'h00000000;
    end else begin
      rf_we_o  <= 1'b0;
      unpred_o <= 1'b0;
      undef_o  <= 1'b0;
      // Order request ends once earlier accesses are observed
      if (mem_order_o && !mem_pending_i)
        mem_order_o <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          instr_ready_o <= enable_reg;
          if (take) begin
            instr_ready_o <= 1'b0;
            instr_reg     <= instr_i;
            op_reg        <= op_in;
            cond_reg      <= cond_i;
            in_it_reg     <= in_it_block_i;
            state_reg     <= S_EXEC;
            if (op_in[`OP_SUB_IMM])
              rf_raddr_a_o <= {1'b0, instr_i[10:8]};
            else if (op_in[`OP_SUB_HI])
              rf_raddr_a_o <= {instr_i[7], instr_i[2:0]};
            else
              rf_raddr_a_o <= {1'b0, instr_i[2:0]};
            if (op_in[`OP_SUB_HI] || op_in[`OP_MOV])
              rf_raddr_b_o <= instr_i[6:3];
            else
              rf_raddr_b_o <= {1'b0, instr_i[5:3]};
          end
        end
        S_EXEC: begin
          state_reg     <= S_IDLE;
          instr_ready_o <= enable_reg;
          if (op_reg == `OP_NONE) begin
            undef_o <= 1'b1;
          end else if (!pass) begin
            // Skipped: no register, flag or barrier effect
            state_reg <= S_IDLE;
          end else if (op_reg[`OP_SUB_HI] && hi_bad) begin
            unpred_o <= 1'b1;
          end else if (op_reg[`OP_MOV] && {hw0[7], hw0[2:0]} == `REG_PC) begin
            unpred_o <= 1'b1;
          end else begin
            count_reg <= count_reg + 32'h00000001;
            if (is_compare) begin
              flag_n_o <= sum[31];
              flag_z_o <= (sum[31:0] == 32'h00000000);
              flag_c_o <= sum[32];
              flag_v_o <= add_v;
            end
            if (op_reg[`OP_MOV]) begin
              rf_we_o    <= 1'b1;
              rf_waddr_o <= {hw0[7], hw0[2:0]};
              rf_wdata_o <= rf_rdata_b_i;
            end
            if (op_reg[`OP_XOR]) begin
              rf_we_o    <= 1'b1;
              rf_waddr_o <= idx_a;
              rf_wdata_o <= xor_res;
              if (!in_it_reg) begin
                flag_n_o <= xor_res[31];
                flag_z_o <= (xor_res == 32'h00000000);
                flag_c_o <= flag_c_o;
              end
            end
            if (op_reg[`OP_ORDER]) begin
              // Every option value acts as full system ordering
              option_reg  <= instr_reg[19:16];
              mem_order_o <= mem_pending_i;
            end
            if (op_reg[`OP_SYNC]) begin
              // Every option value acts as full system completion
              option_reg    <= instr_reg[19:16];
              sync_stall_o  <= 1'b1;
              instr_ready_o <= 1'b0;
              state_reg     <= S_SYNC;
            end
          end
        end
        S_SYNC: begin
          instr_ready_o <= 1'b0;
          if (sync_done) begin
            sync_stall_o  <= 1'b0;
            instr_ready_o <= enable_reg;
            state_reg     <= S_IDLE;
          end
        end
        default: begin
          state_reg     <= S_IDLE;
          instr_ready_o <= 1'b0;
        end
      endcase
    end
  end

  // ========================================================================
  // Wishbone register file
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o          <= 1'b0;
      wb_dat_o          <= 32'h00000000;
      enable_reg        <= `CTRL_ENABLE_RST;
      unpred_sticky_reg <= 1'b0;
      undef_sticky_reg  <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
      if (ctrl_wr)
        enable_reg <= wb_dat_i[`CTRL_ENABLE_BIT];
      // Hardware set wins over a write-one clear in the same cycle
      if (unpred_o)
        unpred_sticky_reg <= 1'b1;
      else if (stat_wr && wb_dat_i[`STAT_UNPRED_BIT])
        unpred_sticky_reg <= 1'b0;
      if (undef_o)
        undef_sticky_reg <= 1'b1;
      else if (stat_wr && wb_dat_i[`STAT_UNDEF_BIT])
        undef_sticky_reg <= 1'b0;
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          `CTRL_REG_ADDR:   wb_dat_o <= {31'h00000000, enable_reg};
          `STATUS_REG_ADDR: wb_dat_o <= status_word;
          `COUNT_REG_ADDR:  wb_dat_o <= count_reg;
          default:          wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

//--- tb/cbx_regfile.sv
// Purpose: Register file on the far side of the decode block
// Assumes: Reads answer in the same cycle, writes land on the strobe edge
// Notes:   Contents are preloaded by the bench
`default_nettype none
module cbx_regfile (
  // Clock
  input  wire logic        clk_i,
  // Read ports
  input  wire logic [3:0]  raddr_a_i,
  input  wire logic [3:0]  raddr_b_i,
  output logic      [31:0] rdata_a_o,
  output logic      [31:0] rdata_b_o,
  // Write port
  input  wire logic        we_i,
  input  wire logic [3:0]  waddr_i,
  input  wire logic [31:0] wdata_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] regs [16];
  assign rdata_a_o = regs[raddr_a_i];
  assign rdata_b_o = regs[raddr_b_i];
  always @(posedge clk_i) begin
    if (we_i) begin
      regs[waddr_i] <= wdata_i;
    end
  end
endmodule
`default_nettype wire

//--- tb/cbx_asserts.sv
// Purpose: Port-level checks of the compare, barrier and xor decode block
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to the top module
`default_nettype none
module cbx_asserts (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Fetch and register file
  input wire logic instr_valid_i,
  input wire logic instr_ready_o,
  input wire logic rf_we_o,
  // Flags and exceptions
  input wire logic flag_n_o,
  input wire logic flag_z_o,
  input wire logic flag_c_o,
  input wire logic flag_v_o,
  input wire logic unpred_o,
  // Memory system
  input wire logic mem_pending_i,
  input wire logic maint_busy_i,
  input wire logic mem_order_o,
  input wire logic sync_stall_o,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic       taken = instr_valid_i && instr_ready_o;
  wire logic [3:0] flags = {flag_n_o, flag_z_o, flag_c_o, flag_v_o};
  // ==========================================================================
  // Properties
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("Bus ack late or held");
  property p_ready_drop; taken |=> !instr_ready_o; endproperty
  a_ready_drop: assert property (p_ready_drop) else $error("Ready stays high after accept");
  property p_we_taken; rf_we_o |-> $past(taken, 2); endproperty
  a_we_taken: assert property (p_we_taken) else $error("Write without accept");
  property p_we_v; rf_we_o |-> $stable(flag_v_o); endproperty
  a_we_v: assert property (p_we_v) else $error("Overflow changed on write");
  property p_unpred_flags; unpred_o |-> $stable(flags); endproperty
  a_unpred_flags: assert property (p_unpred_flags) else $error("Flags moved");
  property p_stall_ready; sync_stall_o |-> !instr_ready_o; endproperty
  a_stall_ready: assert property (p_stall_ready) else $error("Ready during stall");
  property p_stall_clear;
    sync_stall_o && !mem_pending_i && !maint_busy_i |-> ##[1:2] !sync_stall_o;
  endproperty
  a_stall_clear: assert property (p_stall_clear) else $error("Stall not released");
  property p_order_clear; mem_order_o && !mem_pending_i |-> ##[1:2] !mem_order_o; endproperty
  a_order_clear: assert property (p_order_clear) else $error("Order not released");
  c_stall: cover property (sync_stall_o ##1 !sync_stall_o);
  c_order: cover property (mem_order_o);
  c_unpred: cover property (unpred_o);
endmodule

bind compare_barrier_xor_decode cbx_asserts u_cbx_asserts (
  .clk_i(clk_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i), .instr_ready_o(instr_ready_o),
  .rf_we_o(rf_we_o), .flag_n_o(flag_n_o), .flag_z_o(flag_z_o), .flag_c_o(flag_c_o),
  .flag_v_o(flag_v_o), .unpred_o(unpred_o), .mem_pending_i(mem_pending_i),
  .maint_busy_i(maint_busy_i), .mem_order_o(mem_order_o), .sync_stall_o(sync_stall_o),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o)
);
`default_nettype wire

//--- tb/tb_compare_barrier_xor_decode.sv
// Purpose: Self-checking bench of the compare, barrier and xor decode block
// Assumes: Register file model answers in the same cycle
// Notes:   Xorshift operands, flags modelled in the bench
`default_nettype none
`include "cbx_consts.vh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, g, e); end end
module tb_compare_barrier_xor_decode;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 0, rst_i = 1, instr_valid_i = 0, in_it_block_i = 0, wb_cyc_i = 0;
  logic        wb_stb_i = 0, wb_we_i = 0, mem_pending_i = 0, maint_busy_i = 0, instr_ready_o;
  logic        rf_we_o, flag_n_o, flag_z_o, flag_c_o, flag_v_o, mem_order_o, sync_stall_o;
  logic        unpred_o, undef_o, wb_ack_o, mn = 0, mz = 0, mc = 0, mv = 0;
  logic [3:0]  cond_i = 4'hE, wb_adr_i = 4'h0, wb_sel_i = 4'h0, rf_raddr_a_o, rf_raddr_b_o;
  logic [3:0]  rf_waddr_o;
  logic [31:0] instr_i = 0, wb_dat_i = 0, wb_dat_o, rf_rdata_a_i, rf_rdata_b_i, rf_wdata_o;
  logic [31:0] rd, r2, cnt = 0, seed = 32'h52, seed2 = 32'h52, mr [16];
  logic [31:0] bad [3] = '{32'h451A, 32'h45F8, 32'h4697};
  int          checked = 0, err_count = 0;
  always #10 clk_i = ~clk_i;
  compare_barrier_xor_decode uut (.clk_i(clk_i), .rst_i(rst_i), .instr_i(instr_i),
    .instr_valid_i(instr_valid_i), .cond_i(cond_i), .in_it_block_i(in_it_block_i),
    .instr_ready_o(instr_ready_o), .rf_raddr_a_o(rf_raddr_a_o), .rf_raddr_b_o(rf_raddr_b_o),
    .rf_rdata_a_i(rf_rdata_a_i), .rf_rdata_b_i(rf_rdata_b_i), .rf_we_o(rf_we_o),
    .rf_waddr_o(rf_waddr_o), .rf_wdata_o(rf_wdata_o), .flag_n_o(flag_n_o), .flag_z_o(flag_z_o),
    .flag_c_o(flag_c_o), .flag_v_o(flag_v_o), .mem_pending_i(mem_pending_i),
    .maint_busy_i(maint_busy_i), .mem_order_o(mem_order_o), .sync_stall_o(sync_stall_o),
    .unpred_o(unpred_o), .undef_o(undef_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
  cbx_regfile rf (.clk_i(clk_i), .raddr_a_i(rf_raddr_a_o), .raddr_b_i(rf_raddr_b_o),
    .rdata_a_o(rf_rdata_a_i), .rdata_b_o(rf_rdata_b_i), .we_i(rf_we_o),
    .waddr_i(rf_waddr_o), .wdata_i(rf_wdata_o));
  // ==========================================================================
  // Helpers
  function automatic logic [31:0] xs(inout logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic addf(input logic [31:0] a, input logic [31:0] b, input logic ci);
    logic [32:0] s;
    s = {1'b0, a} + {1'b0, b} + {32'h0, ci};
    {mn, mz, mc} = {s[31], s[31:0] == 32'h0, s[32]};
    mv = (a[31] == b[31]) && (s[31] != a[31]);
  endtask
  task automatic end_sim;
    $display("checked=%0d err_count=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic waitfor(input int lim, input int sel);
    for (int i = 0; i <= lim; i++) begin
      @(posedge clk_i);
      if ((sel ? wb_ack_o : instr_ready_o) === 1'b1) break;
      if (i == lim) begin err_count++; end_sim(); end
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, w, a, d, 4'hF};
    waitfor(50, 1);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  task automatic issue(input logic [31:0] ins, input logic [3:0] cd, input logic it);
    @(posedge clk_i);
    {instr_i, cond_i, in_it_block_i, instr_valid_i} <= {ins, cd, it, 1'b1};
    waitfor(50, 0);
    instr_valid_i <= 1'b0;
    waitfor(200, 0);
    @(posedge clk_i);
    #1;
  endtask
  task automatic step(input int k);
    logic [31:0] r, ins;
    logic [3:0]  n, m, cd, d;
    r = xs(seed);
    n = (r[3:0] == 4'hF) ? 4'hE : r[3:0];
    m = (r[7:4] == 4'hF) ? 4'hE : r[7:4];
    if (k == 3 && n < 8 && m < 8) m = {2'b10, m[1:0]};
    cd = r[9] ? {3'h0, ~r[8]} : `COND_ALWAYS;
    d = (k == 4) ? n : {1'b0, n[2:0]};
    case (k)
      0: ins = {16'h0, `OPC_COMPARE_NEG, m[2:0], n[2:0]};
      1: ins = {16'h0, `OPC_COMPARE_IMM, n[2:0], r[23:16]};
      2: ins = {16'h0, `OPC_COMPARE_LO, m[2:0], n[2:0]};
      3: ins = {16'h0, `OPC_COMPARE_HI, n[3], m, n[2:0]};
      4: ins = {16'h0, `OPC_MOVE, n[3], m, n[2:0]};
      5: ins = {16'h0, `OPC_XOR, m[2:0], n[2:0]};
      default: ins = {8'h8F, (k == 6) ? `OPC_ORDER_BAR : `OPC_SYNC_BAR, r[15:12], 16'hF3BF};
    endcase
    if (cd == `COND_ALWAYS || (cd == 4'h0 && mz) || (cd == 4'h1 && !mz)) begin
      cnt++;
      case (k)
        0: addf(mr[d], mr[m[2:0]], 1'b0);
        1: addf(mr[d], ~{24'h0, r[23:16]}, 1'b1);
        2: addf(mr[d], ~mr[m[2:0]], 1'b1);
        3: addf(mr[n], ~mr[m], 1'b1);
        4: mr[d] = mr[m];
        5: begin
          mr[d] = mr[d] ^ mr[m[2:0]];
          if (!r[10]) {mn, mz} = {mr[d][31], mr[d] == 32'h0};
        end
        default: ;
      endcase
    end
    issue(ins, cd, r[10]);
    `CHK({flag_n_o, flag_z_o, flag_c_o, flag_v_o}, {mn, mz, mc, mv})
    `CHK(rf.regs[d], mr[d])
    `CHK(sync_stall_o, 1'b0)
  endtask
  always @(posedge clk_i) begin
    r2 = xs(seed2);
    {mem_pending_i, maint_busy_i} <= {r2[3], r2[9] & r2[4]};
  end
  // ==========================================================================
  // Main sequence
  initial begin
    for (int i = 0; i < 16; i++) mr[i] = (i < 2) ? {i[0], 31'h7FFFFFFF} : xs(seed);
    for (int i = 0; i < 16; i++) rf.regs[i] = mr[i];
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, `CTRL_REG_ADDR, 32'h0);
    `CHK(rd, `CTRL_RESET_VAL)
    wb(1'b0, 4'hC, 32'h0);
    `CHK(rd, 32'h0)
    for (int i = 0; i < 300; i++) step((i < 16) ? i % 8 : int'(xs(seed) % 8));
    wb(1'b1, `COUNT_REG_ADDR, 32'h0);
    wb(1'b0, `COUNT_REG_ADDR, 32'h0);
    `CHK(rd, cnt)
    for (int i = 0; i < 3; i++) begin
      issue(bad[i], `COND_ALWAYS, 1'b0);
      `CHK({flag_n_o, flag_z_o, flag_c_o, flag_v_o}, {mn, mz, mc, mv})
      `CHK(rf.regs[15], mr[15])
    end
    wb(1'b0, `STATUS_REG_ADDR, 32'h0);
    `CHK(rd[6:0], {1'b1, 2'b00, mn, mz, mc, mv})
    wb(1'b1, `STATUS_REG_ADDR, 32'h40);
    wb(1'b0, `STATUS_REG_ADDR, 32'h0);
    `CHK(rd[6], 1'b0)
    issue(32'h0, `COND_ALWAYS, 1'b0);
    `CHK(rf.regs[0], mr[0])
    wb(1'b0, `STATUS_REG_ADDR, 32'h0);
    `CHK(rd[7], 1'b1)
    wb(1'b1, `CTRL_REG_ADDR, 32'h0);
    repeat (3) @(posedge clk_i);
    #1;
    `CHK(instr_ready_o, 1'b0)
    end_sim();
  end
endmodule
`default_nettype wire
